//--- verilog/nvh_pkg.sv
package nvh_pkg;
	// bus geometry
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int SEQ_LEN = 6;
	localparam int CLK_NS = 10;
	// unlock sequence addresses
	localparam logic [12:0] SEQ_A0 = 13'h0000;
	localparam logic [12:0] SEQ_A1 = 13'h1555;
	localparam logic [12:0] SEQ_A2 = 13'h0aaa;
	localparam logic [12:0] SEQ_A3 = 13'h1fff;
	localparam logic [12:0] SEQ_A4 = 13'h10f0;
	localparam logic [12:0] SEQ_SAVE = 13'h0f0f;
	localparam logic [12:0] SEQ_RESTORE = 13'h0f0e;
	localparam logic [12:0] SEQ_TEST = 13'h139c;
	// timing in printed units
	localparam int SELECT_PULSE_NS = 35;
	localparam int ACCESS_NS = 45;
	localparam int IDLE_NS = 20;
	localparam int SAVE_MS = 10;
	localparam int RESTORE_US = 20;
	localparam int POWERUP_US = 650;
	// cycle counts; least times round up
	localparam int SELECT_CYC = (SELECT_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAVE_CYC = SAVE_MS * 1000000 / CLK_NS;
	localparam int RESTORE_CYC = RESTORE_US * 1000 / CLK_NS;
	localparam int POWERUP_CYC = POWERUP_US * 1000 / CLK_NS;
	// host sequencer states
	typedef enum logic [2:0] {
		NVH_POWERUP = 3'b000,
		NVH_IDLE = 3'b001,
		NVH_ACTIVE = 3'b011,
		NVH_RECOVER = 3'b010,
		NVH_BUSY = 3'b110
	} nvh_state_e;
	// user commands
	typedef enum logic [1:0] {
		NVH_CMD_READ = 2'h0,
		NVH_CMD_WRITE = 2'h1,
		NVH_CMD_SAVE = 2'h2,
		NVH_CMD_RESTORE = 2'h3
	} nvh_cmd_e;
endpackage : nvh_pkg

//--- verilog/nvh_timer.sv
`timescale 1ns/1ps
// down counter for the long nonvolatile waits
module nvh_timer #(
	parameter int W = 24
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// done is high while the count rests at zero
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_val;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign done = (count == '0);
endmodule : nvh_timer

//--- verilog/nvh_host.sv
`timescale 1ns/1ps
// Overview of operation
// R1: save needs six ordered reads ending 0f0f
// R2: sixth address picks save or restore
// R3: write strobe high during sequence reads
// R4: output gate irrelevant to sequence recognition
// R5: never issue the reserved 139c sequence
// R6: one select pulse per sequence address
// R7: device ignores inputs while operation runs
// R8: sixth access data lines float
// R9: save completes within ten milliseconds
// R10: restore completes within twenty microseconds
// R11: low supply aborts save, not restore
// R12: automatic restore at power up
// R13: repeated same-address read breaks sequence
// R14: short select pulse still advances sequence
// R15: read when select and gate low
// R16: outputs follow address during read
// R17: write captured when first strobe rises
// R18: address stable throughout write cycle
// R19: gate held high during write
// R20: device disables drivers on write
// R21: ordinary access suspended during transfer
// R22: intervening access aborts the sequence
// R23: restore clears then copies nonvolatile data
// R24: power-up restore done within 650 us
// R25: memory usable again after save
// R26: mismatch resets detector, 0000 restarts
// R27: detector starts empty after each operation
module nvh_host
	import nvh_pkg::*;
#(
	parameter int POWERUP_WAIT = nvh_pkg::POWERUP_CYC,
	parameter int SAVE_WAIT = nvh_pkg::SAVE_CYC,
	parameter int RESTORE_WAIT = nvh_pkg::RESTORE_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire nvh_pkg::nvh_cmd_e cmd_op,
	input wire logic [nvh_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [nvh_pkg::DATA_W-1:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [nvh_pkg::DATA_W-1:0] rsp_rdata,
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_gate_n,
	output logic [nvh_pkg::ADDR_W-1:0] addr_lines,
	output logic [nvh_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe,
	input wire logic [nvh_pkg::DATA_W-1:0] data_lines_i
);
	import nvh_pkg::*;

	localparam int TW = 24;

	nvh_state_e state;
	nvh_state_e next_state;
	nvh_cmd_e op;
	nvh_cmd_e next_op;
	logic [2:0] step;
	logic [2:0] next_step;
	logic [3:0] phase;
	logic [3:0] next_phase;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] next_wdata;
	logic next_cs_n;
	logic next_we_n;
	logic next_oe_n;
	logic next_dq_oe;
	logic next_ready;
	logic next_rsp_valid;
	logic [DATA_W-1:0] next_rsp_rdata;
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;
	logic tmr_load;
	logic [TW-1:0] tmr_val;
	logic tmr_done;

	// one long wait timer shared by power-up, save and restore
	nvh_timer #(
		.W(TW)
	) u_timer (
		.mclk(mclk),
		.reset(reset),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	// read data come from a pin, so two flops before use
	always_ff @(posedge mclk) begin
		dq_meta <= data_lines_i;
		dq_sync <= dq_meta;
	end

	// address of each unlock step; last one chooses the operation
	function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvh_cmd_e o);
		case (s)
			3'd0: seq_addr = SEQ_A0; // [R1]
			3'd1: seq_addr = SEQ_A1;
			3'd2: seq_addr = SEQ_A2;
			3'd3: seq_addr = SEQ_A3;
			3'd4: seq_addr = SEQ_A4;
			default: seq_addr = (o == NVH_CMD_SAVE) ? SEQ_SAVE : SEQ_RESTORE; // [R2]
		endcase
	endfunction : seq_addr

	// bus sequencer; one access per phase run, strobes idle between
	always_comb begin
		next_state = state;
		next_op = op;
		next_step = step;
		next_phase = phase;
		next_addr = addr_lines;
		next_wdata = wdata;
		next_cs_n = 1'b1;
		next_we_n = 1'b1;
		next_oe_n = 1'b1;
		next_dq_oe = 1'b0;
		next_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		tmr_load = 1'b0;
		tmr_val = '0;
		case (state)
			NVH_POWERUP: begin
				// device restores itself; no access until it is done
				// timer rests at zero before it is armed, so skip phase 0
				if (phase != 4'd0 && tmr_done) begin // [R12] [R24]
					next_state = NVH_IDLE;
					next_ready = 1'b1;
				end
			end
			NVH_IDLE: begin
				next_ready = 1'b1;
				if (cmd_valid) begin
					next_ready = 1'b0;
					next_op = cmd_op;
					next_wdata = cmd_wdata;
					next_step = 3'd0;
					next_phase = 4'd0;
					next_state = NVH_ACTIVE;
					// sequence always starts at 0000, never the test address
					if (cmd_op == NVH_CMD_SAVE || cmd_op == NVH_CMD_RESTORE) begin
						next_addr = seq_addr(3'd0, cmd_op); // [R5] [R27]
					end else begin
						next_addr = cmd_addr;
					end
				end
			end
			NVH_ACTIVE: begin
				next_phase = phase + 4'd1;
				next_cs_n = 1'b0; // [R6]
				if (op == NVH_CMD_WRITE) begin
					// gate stays high so the bus has one driver
					next_oe_n = 1'b1; // [R19]
					next_we_n = 1'b0; // [R17]
					next_dq_oe = 1'b1;
				end else begin
					// sequence reads keep write high; gate low is harmless
					next_we_n = 1'b1; // [R3]
					next_oe_n = (op == NVH_CMD_READ) ? 1'b0 : 1'b1; // [R4] [R15]
				end
				if (phase == 4'(ACCESS_CYC - 1)) begin
					// select pulse four cycles: wide enough for sequence clocking, one cycle short of ACCESS_CYC
					next_cs_n = 1'b1; // [R14]
					next_we_n = 1'b1;
					next_oe_n = 1'b1;
					// data held one more cycle past write end
					next_dq_oe = (op == NVH_CMD_WRITE); // [R18]
					next_phase = 4'd0;
					next_state = NVH_RECOVER;
					if (op == NVH_CMD_READ) begin
						next_rsp_rdata = dq_sync; // [R16]
					end
				end
			end
			NVH_RECOVER: begin
				// address held while strobes high, then step on
				next_phase = phase + 4'd1;
				if (phase == 4'(IDLE_CYC - 1)) begin
					next_phase = 4'd0;
					if (op == NVH_CMD_READ || op == NVH_CMD_WRITE) begin
						next_rsp_valid = 1'b1;
						next_ready = 1'b1;
						next_state = NVH_IDLE;
					end else if (step == 3'(SEQ_LEN - 1)) begin
						// sixth strobe has started the transfer
						tmr_load = 1'b1;
						tmr_val = (op == NVH_CMD_SAVE) ? TW'(SAVE_WAIT) : TW'(RESTORE_WAIT); // [R9] [R10]
						next_state = NVH_BUSY;
					end else begin
						// distinct addresses back to back, nothing in between
						next_step = step + 3'd1; // [R13] [R22] [R26]
						next_addr = seq_addr(next_step, op);
						next_state = NVH_ACTIVE;
					end
				end
			end
			NVH_BUSY: begin
				// bus quiet until the transfer time is spent
				if (tmr_done) begin // [R7] [R21] [R25]
					next_rsp_valid = 1'b1;
					next_ready = 1'b1;
					next_state = NVH_IDLE;
				end
			end
			default: begin
				next_state = NVH_IDLE;
			end
		endcase
		if (state == NVH_POWERUP && phase == 4'd0) begin
			// first cycle after reset arms the power-up wait
			tmr_load = 1'b1;
			tmr_val = TW'(POWERUP_WAIT);
			next_phase = 4'd1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= NVH_POWERUP;
			op <= NVH_CMD_READ;
			step <= 3'd0;
			phase <= 4'd0;
			addr_lines <= '0;
			wdata <= '0;
			chip_select_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
			data_lines_oe <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			state <= next_state;
			op <= next_op;
			step <= next_step;
			phase <= (next_state == NVH_IDLE) ? 4'd0 : next_phase;
			addr_lines <= next_addr;
			wdata <= next_wdata;
			chip_select_n <= next_cs_n;
			write_strobe_n <= next_we_n;
			output_gate_n <= next_oe_n;
			data_lines_oe <= next_dq_oe;
			cmd_ready <= next_ready;
			rsp_valid <= next_rsp_valid;
			rsp_rdata <= next_rsp_rdata;
		end
	end

	// write data registered straight to the pins
	always_ff @(posedge mclk) begin
		data_lines_o <= wdata;
	end
endmodule : nvh_host

//--- verif/nvh_host_sva.sv
`timescale 1ns/1ps
module nvh_host_sva
	import nvh_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire nvh_pkg::nvh_cmd_e cmd_op,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic [nvh_pkg::ADDR_W-1:0] addr_lines,
	input wire logic data_lines_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic take;
	// request accepted this edge
	assign take = cmd_valid && cmd_ready;
	a_gate_in_write: assert property (!write_strobe_n |-> output_gate_n) else $error("gate low in write");
	a_drive_in_write: assert property (!write_strobe_n |-> data_lines_oe) else $error("no data in write");
	a_no_contention: assert property (!output_gate_n |-> !data_lines_oe) else $error("bus contention");
	a_addr_held: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(addr_lines))
		else $error("address moved");
	a_select_width: assert property ($fell(chip_select_n) |-> !chip_select_n [*4]) else $error("select short");
	a_seq_start: assert property (take && cmd_op inside {NVH_CMD_SAVE, NVH_CMD_RESTORE} |=> addr_lines == SEQ_A0)
		else $error("sequence start");
	a_seq_no_write: assert property (take && cmd_op inside {NVH_CMD_SAVE, NVH_CMD_RESTORE} |=> write_strobe_n [*8])
		else $error("write in sequence");
	a_access_time: assert property (take && cmd_op inside {NVH_CMD_READ, NVH_CMD_WRITE} |-> ##[7:8] rsp_valid)
		else $error("access late");
	a_save_busy: assert property (take && cmd_op == NVH_CMD_SAVE |=> !cmd_ready [*8]) else $error("ready in save");
	c_save: cover property (take && cmd_op == NVH_CMD_SAVE);
	c_restore: cover property (take && cmd_op == NVH_CMD_RESTORE);
	c_write: cover property (take && cmd_op == NVH_CMD_WRITE);
	c_read: cover property (take && cmd_op == NVH_CMD_READ);
endmodule : nvh_host_sva
bind nvh_host nvh_host_sva u_sva (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
	.output_gate_n(output_gate_n), .addr_lines(addr_lines), .data_lines_oe(data_lines_oe));

//--- verif/nvh_dev_model.sv
`timescale 1ns/1ps
module nvh_dev_model
	import nvh_pkg::*;
(
	input wire logic mclk,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic [nvh_pkg::ADDR_W-1:0] addr_lines,
	input wire logic [nvh_pkg::DATA_W-1:0] data_lines_o,
	output logic [nvh_pkg::DATA_W-1:0] data_lines_i
);
	localparam logic [12:0] SEQ [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
	logic [7:0] mem [8192];
	logic [7:0] nv [8192];
	logic [2:0] step;
	logic cs_q;
	logic we_q;
	logic [7:0] last;
	int busy;
	// power-up restore, kept shorter than the host's power-up wait
	initial begin
		for (int i = 0; i < 8192; i++) nv[i] = i[7:0] ^ 8'h5a;
		mem = nv;
		busy = 15;
		step = 0;
		cs_q = 1;
		we_q = 1;
		last = 0;
	end
	// strobe edges clock the detector and the array
	always @(posedge mclk) begin
		cs_q <= chip_select_n;
		we_q <= write_strobe_n;
		last <= data_lines_i;
		if (busy > 0) begin
			busy <= busy - 1; // pins ignored meanwhile
		end else begin
			if (!cs_q && !we_q && (chip_select_n || write_strobe_n))
				mem[addr_lines] <= data_lines_o; // first strobe up
			if (!chip_select_n && !write_strobe_n)
				step <= 0;
			else if (!chip_select_n && cs_q) begin // gate ignored
				if (step == 5 && addr_lines inside {SEQ_SAVE, SEQ_RESTORE}) begin
					busy <= (addr_lines == SEQ_SAVE) ? 40 : 15;
					if (addr_lines == SEQ_SAVE)
						nv <= mem;
					else
						mem <= nv;
					step <= 0;
				end else if (step < 5 && addr_lines == SEQ[step])
					step <= step + 1;
				else
					step <= 3'(addr_lines == SEQ_A0);
			end
		end
	end
	// a floated line shows a changing value, never a stale one
	assign data_lines_i = (!chip_select_n && !output_gate_n && write_strobe_n && busy == 0) ? mem[addr_lines]
		: ~last;
endmodule : nvh_dev_model

//--- verif/nvh_host_tb_top.sv
`timescale 1ns/1ps
module nvh_host_tb_top;
	import nvh_pkg::*;
	logic mclk = 0;
	logic reset = 1;
	logic cmd_valid = 0;
	nvh_cmd_e cmd_op = NVH_CMD_READ;
	logic [12:0] cmd_addr = 0;
	logic [7:0] cmd_wdata = 0;
	logic cmd_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n, data_lines_oe;
	logic [12:0] addr_lines;
	logic [7:0] rsp_rdata, data_lines_o, data_lines_i;
	logic [7:0] sh [8192];
	logic [7:0] nvsh [8192];
	int fail_count = 0;
	int n_compared = 0;
	always #5 mclk = ~mclk;
	// short waits keep the run small
	nvh_host #(.POWERUP_WAIT(20), .SAVE_WAIT(50), .RESTORE_WAIT(20)) u_dut (.mclk(mclk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
		.output_gate_n(output_gate_n), .addr_lines(addr_lines), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
	nvh_dev_model u_mem (.mclk(mclk), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
		.output_gate_n(output_gate_n), .addr_lines(addr_lines), .data_lines_o(data_lines_o),
		.data_lines_i(data_lines_i));
	function automatic logic [7:0] exp_rd(input logic [12:0] a);
		return sh[a];
	endfunction : exp_rd
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	// one request, held until taken, then bounded wait for the answer
	task automatic do_cmd(input nvh_cmd_e op, input logic [12:0] a, input logic [7:0] d);
		int t;
		@(posedge mclk);
		cmd_valid <= 1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		do @(posedge mclk); while (cmd_ready !== 1'b1);
		cmd_valid <= 0;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (rsp_valid !== 1'b1 && t < 3000);
		chk("rsp_valid", 8'h1, {7'h0, rsp_valid});
	endtask : do_cmd
	initial begin
		logic [12:0] a;
		logic [7:0] d;
		void'($urandom(32'h36b49374));
		for (int i = 0; i < 8192; i++) sh[i] = i[7:0] ^ 8'h5a;
		repeat (5) @(posedge mclk);
		reset <= 0;
		do_cmd(NVH_CMD_READ, 13'h0123, 8'h00);
		chk("powerup data", exp_rd(13'h0123), rsp_rdata);
		// random traffic, reads land on fresh and untouched bytes alike
		repeat (30) begin
			a = 13'($urandom);
			d = 8'($urandom);
			do_cmd(NVH_CMD_WRITE, a, d);
			sh[a] = d;
			if ($urandom % 2 == 1)
				a = 13'($urandom);
			do_cmd(NVH_CMD_READ, a, 8'h00);
			chk("read data", exp_rd(a), rsp_rdata);
		end
		do_cmd(NVH_CMD_WRITE, SEQ_SAVE, 8'h3c);
		sh[SEQ_SAVE] = 8'h3c;
		do_cmd(NVH_CMD_SAVE, 13'h0000, 8'h00);
		nvsh = sh;
		do_cmd(NVH_CMD_WRITE, SEQ_SAVE, 8'hc3);
		sh[SEQ_SAVE] = 8'hc3;
		do_cmd(NVH_CMD_READ, SEQ_SAVE, 8'h00);
		chk("after save", exp_rd(SEQ_SAVE), rsp_rdata);
		do_cmd(NVH_CMD_RESTORE, 13'h0000, 8'h00);
		sh = nvsh;
		do_cmd(NVH_CMD_READ, SEQ_SAVE, 8'h00);
		chk("after restore", exp_rd(SEQ_SAVE), rsp_rdata);
		end_of_test();
	end
	// run needs under a thousand cycles; this is over thirty times that
	initial begin
		#300000;
		fail_count++;
		end_of_test();
	end
endmodule : nvh_host_tb_top
